// [design/hsph_host_select.sv]
// Host interface selection, pin routing and sleep handshake
`timescale 1ns/100ps
`default_nettype none

module hsph_host_select (
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Strap pins
  input  wire logic               host_sel_0_in,
  input  wire logic               host_sel_1_in,
  output var  hsph_pkg::hsph_mode_e host_mode,
  output var  logic               strap_done,
  // Shared host pins: command/select and four data lines
  input  wire logic               host_cmd_in,
  output var  logic               host_cmd_out,
  output var  logic               host_cmd_oe,
  input  wire logic [3:0]         host_dat_in,
  output var  logic [3:0]         host_dat_out,
  output var  logic [3:0]         host_dat_oe,
  // Core side of the shared pins
  output var  logic               host_cmd_rx,
  output var  logic [3:0]         host_dat_rx,
  output var  logic               spi_active,
  input  wire logic               spi_tx_bit,
  input  wire logic               sdio_cmd_tx,
  input  wire logic               sdio_cmd_tx_en,
  input  wire logic [3:0]         sdio_dat_tx,
  input  wire logic [3:0]         sdio_dat_tx_en,
  // Host interrupt
  input  wire logic               irq_req,
  input  wire hsph_pkg::hsph_irq_e irq_style,
  // Host wakeup pin
  input  wire logic               wake_irq_en,
  input  wire logic               wake_active_low,
  input  wire logic               pkt_pending,
  output var  logic               host_wake_out,
  output var  logic               host_wake_oe,
  // UART host pins
  input  wire logic               host_serial_rx,
  output var  logic               host_serial_tx,
  output var  logic               host_serial_tx_oe,
  output var  logic               host_serial_rts,
  output var  logic               host_serial_rts_oe,
  input  wire logic               host_serial_cts,
  output var  logic               serial_rx_data,
  output var  logic               serial_cts_seen,
  input  wire logic               serial_tx_data,
  input  wire logic               serial_rts_req,
  // Boot and sleep
  input  wire logic               boot_done,
  input  wire logic               boot_bypass_in,
  output var  logic               skip_host_cmds,
  input  wire logic               light_sleep_req,
  input  wire logic               deep_sleep_req,
  input  wire logic               handshake_en,
  input  wire logic               deep_sleep_wake_in,
  output var  hsph_pkg::hsph_sleep_e sleep_state,
  output var  hsph_pkg::hsph_sleep_s sleep_pins,
  // Coexistence
  input  wire logic               coex_en,
  input  wire logic               wlan_tx_busy,
  output var  logic               radio_tx_active_out,
  input  wire logic               peer_priority_in,
  input  wire logic               peer_tx_active_in,
  output var  logic               peer_priority,
  output var  logic               peer_tx_active
);

  // ==========================================================
  // Pin synchronisers
  logic [hsph_pkg::HSPH_S_WIDTH-1:0] raw;
  logic [hsph_pkg::HSPH_S_WIDTH-1:0] s;
  logic [1:0]                        strap_cnt;
  logic                              spi_select_n;
  logic                              light_sleep_wake_in;
  logic                              deep_wake_s;
  hsph_pkg::hsph_sleep_e             next_sleep;

  assign raw = {peer_tx_active_in, peer_priority_in, deep_sleep_wake_in,
                boot_bypass_in, host_serial_cts, host_serial_rx,
                host_dat_in, host_cmd_in, host_sel_1_in, host_sel_0_in};

  hsph_sync #(.WIDTH(hsph_pkg::HSPH_S_WIDTH)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (raw),
    .q     (s)
  );

  // Synchronised views
  assign spi_select_n        = s[hsph_pkg::HSPH_S_CMD];
  assign light_sleep_wake_in = s[hsph_pkg::HSPH_S_BYPASS];
  assign deep_wake_s         = s[hsph_pkg::HSPH_S_DWAKE];
  assign host_cmd_rx         = s[hsph_pkg::HSPH_S_CMD];
  assign host_dat_rx         = s[hsph_pkg::HSPH_S_DAT +: 4];
  assign serial_rx_data      = s[hsph_pkg::HSPH_S_RX];
  assign serial_cts_seen     = s[hsph_pkg::HSPH_S_CTS];

  // ==========================================================
  // Strap latch, taken once after the synchroniser has filled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt  <= '0;
      strap_done <= 1'b0;
      host_mode  <= hsph_pkg::HSPH_MODE_RST;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == hsph_pkg::HSPH_STRAP_SETTLE) begin
        strap_done <= 1'b1;
        unique case ({s[hsph_pkg::HSPH_S_SEL1], s[hsph_pkg::HSPH_S_SEL0]})
          2'h2:    host_mode <= hsph_pkg::HSPH_SPI;
          2'h1:    host_mode <= hsph_pkg::HSPH_USB;
          2'h0:    host_mode <= hsph_pkg::HSPH_UART;
          2'h3:    host_mode <= hsph_pkg::HSPH_SDIO;
        endcase
      end
    end
  end

  // SPI addressed while select low
  assign spi_active = strap_done && (host_mode == hsph_pkg::HSPH_SPI)
                      && !spi_select_n;

  // ==========================================================
  // Shared host pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_cmd_out <= 1'b0;
      host_cmd_oe  <= 1'b0;
      host_dat_out <= '0;
      host_dat_oe  <= '0;
    end else begin
      host_cmd_out <= 1'b0;
      host_cmd_oe  <= 1'b0;
      host_dat_out <= '0;
      host_dat_oe  <= '0;
      if (strap_done && host_mode == hsph_pkg::HSPH_SDIO) begin
        host_cmd_out <= sdio_cmd_tx;
        host_cmd_oe  <= sdio_cmd_tx_en;
        host_dat_out <= sdio_dat_tx;
        host_dat_oe  <= sdio_dat_tx_en;
      end else if (strap_done && host_mode == hsph_pkg::HSPH_SPI) begin
        host_dat_out[1] <= spi_tx_bit;
        host_dat_oe[1]  <= !spi_select_n;
        unique case (irq_style)
          hsph_pkg::HSPH_IRQ_HIGH: begin
            host_dat_out[2] <= irq_req;
            host_dat_oe[2]  <= 1'b1;
          end
          hsph_pkg::HSPH_IRQ_LOW: begin
            host_dat_out[2] <= !irq_req;
            host_dat_oe[2]  <= 1'b1;
          end
          default: begin
            host_dat_out[2] <= 1'b0;
            host_dat_oe[2]  <= irq_req;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // UART pins and host wakeup pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_serial_tx     <= 1'b1;
      host_serial_tx_oe  <= 1'b0;
      host_serial_rts    <= 1'b1;
      host_serial_rts_oe <= 1'b0;
    end else begin
      host_serial_tx     <= serial_tx_data;
      host_serial_rts    <= serial_rts_req;
      host_serial_tx_oe  <= strap_done && host_mode == hsph_pkg::HSPH_UART;
      host_serial_rts_oe <= strap_done && host_mode == hsph_pkg::HSPH_UART;
    end
  end

  // Wakeup pin, polarity set by wake_active_low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_wake_out <= 1'b0;
      host_wake_oe  <= 1'b0;
    end else begin
      host_wake_oe  <= wake_irq_en;
      host_wake_out <= (wake_irq_en && pkt_pending) ^ wake_active_low;
    end
  end

  // ==========================================================
  // Boot bypass and sleep control
  assign skip_host_cmds = !boot_done && light_sleep_wake_in;

  always_comb begin
    next_sleep = sleep_state;
    unique case (sleep_state)
      hsph_pkg::HSPH_AWAKE: begin
        if (deep_sleep_req) next_sleep = hsph_pkg::HSPH_DEEP;
        else if (light_sleep_req) next_sleep = hsph_pkg::HSPH_LIGHT;
      end
      hsph_pkg::HSPH_LIGHT: begin
        if (deep_sleep_req) next_sleep = hsph_pkg::HSPH_DEEP;
        else if (boot_done && light_sleep_wake_in)
          next_sleep = hsph_pkg::HSPH_AWAKE;
      end
      hsph_pkg::HSPH_DEEP: begin
        if (deep_wake_s) next_sleep = hsph_pkg::HSPH_AWAKE;
      end
      default: next_sleep = hsph_pkg::HSPH_AWAKE;
    endcase
  end

  // Sleep state and indication pins move together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_state <= hsph_pkg::HSPH_AWAKE;
      sleep_pins  <= hsph_pkg::HSPH_SLEEP_RST;
    end else begin
      sleep_state          <= next_sleep;
      sleep_pins.status_a  <= !(handshake_en &&
                              next_sleep != hsph_pkg::HSPH_AWAKE);
      sleep_pins.status_b  <= next_sleep != hsph_pkg::HSPH_DEEP;
      sleep_pins.supply_on <= next_sleep != hsph_pkg::HSPH_DEEP;
    end
  end

  // ==========================================================
  // Coexistence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_tx_active_out <= 1'b0;
      peer_priority       <= 1'b0;
      peer_tx_active      <= 1'b0;
    end else begin
      radio_tx_active_out <= coex_en && wlan_tx_busy;
      peer_priority  <= coex_en && s[hsph_pkg::HSPH_S_PRIO];
      peer_tx_active <= coex_en && s[hsph_pkg::HSPH_S_PACT];
    end
  end

  // ==========================================================
  // Assertions
  property p_miso;
    @(posedge clk) disable iff (!rst_n)
    strap_done && host_mode == hsph_pkg::HSPH_SPI && !spi_select_n
    |=> host_dat_oe[1] && host_dat_out[1] == $past(spi_tx_bit);
  endproperty
  a_miso: assert property (p_miso) else $error("miso not driven");

  property p_sdio_cmd;
    @(posedge clk) disable iff (!rst_n)
    strap_done && host_mode == hsph_pkg::HSPH_SDIO && sdio_cmd_tx_en
    |=> host_cmd_oe && host_cmd_out == $past(sdio_cmd_tx);
  endproperty
  a_sdio_cmd: assert property (p_sdio_cmd) else $error("sdio cmd");

  property p_irq_drain;
    @(posedge clk) disable iff (!rst_n)
    strap_done && host_mode == hsph_pkg::HSPH_SPI
    && irq_style == hsph_pkg::HSPH_IRQ_DRAIN
    |=> host_dat_oe[2] == $past(irq_req) && !host_dat_out[2];
  endproperty
  a_irq_drain: assert property (p_irq_drain) else $error("irq drain");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
    wake_irq_en && pkt_pending
    |=> host_wake_oe && host_wake_out == !$past(wake_active_low);
  endproperty
  a_wake: assert property (p_wake) else $error("wake pin");

  property p_light_wake;
    @(posedge clk) disable iff (!rst_n)
    sleep_state == hsph_pkg::HSPH_LIGHT && boot_done
    && light_sleep_wake_in && !deep_sleep_req
    |=> sleep_state == hsph_pkg::HSPH_AWAKE && sleep_pins.status_a;
  endproperty
  a_light_wake: assert property (p_light_wake) else $error("lp wake");

  property p_status_a;
    @(posedge clk) disable iff (!rst_n)
    handshake_en && next_sleep != hsph_pkg::HSPH_AWAKE
    |=> !sleep_pins.status_a;
  endproperty
  a_status_a: assert property (p_status_a) else $error("status a");

  property p_deep_pins;
    @(posedge clk) disable iff (!rst_n)
    sleep_state == hsph_pkg::HSPH_DEEP
    |-> !sleep_pins.status_b && !sleep_pins.supply_on;
  endproperty
  a_deep_pins: assert property (p_deep_pins) else $error("deep pins");

  property p_deep_wake;
    @(posedge clk) disable iff (!rst_n)
    sleep_state == hsph_pkg::HSPH_DEEP && deep_wake_s
    |=> sleep_state == hsph_pkg::HSPH_AWAKE && sleep_pins.status_b;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("ulp wake");

  property p_uart;
    @(posedge clk) disable iff (!rst_n)
    strap_done && host_mode == hsph_pkg::HSPH_UART
    |=> host_serial_tx_oe && host_serial_rts_oe;
  endproperty
  a_uart: assert property (p_uart) else $error("uart pins");

  property p_coex;
    @(posedge clk) disable iff (!rst_n)
    coex_en && wlan_tx_busy |=> radio_tx_active_out;
  endproperty
  a_coex: assert property (p_coex) else $error("coex out");

  c_deep: cover property (@(posedge clk) disable iff (!rst_n)
    sleep_state == hsph_pkg::HSPH_DEEP ##1
    sleep_state == hsph_pkg::HSPH_AWAKE);
  c_light: cover property (@(posedge clk) disable iff (!rst_n)
    sleep_state == hsph_pkg::HSPH_LIGHT ##1
    sleep_state == hsph_pkg::HSPH_AWAKE);
  c_spi: cover property (@(posedge clk) disable iff (!rst_n)
    spi_active && irq_req);

endmodule : hsph_host_select

`default_nettype wire

// [design/hsph_pkg.sv]
// Package: constants and types of the host select and power handshake block
//
// Behaviour
// - In SPI mode we send on the slave-output pin, sample slave-input.
// - In SDIO mode one two-way command line and four data lines.
// - SPI interrupt output is active-high, active-low or open-drain.
// - With wakeup mode enabled, wakeup output flags a pending packet.
// - High bypass input while booting ignores host, boots default image.
// - After boot, high on that input wakes from light sleep.
// - With handshake on, status A low in either sleep, high on exit.
// - Status B low during deep sleep, high after leaving it.
// - High deep sleep wake input ends deep sleep.
// - Two strap pins select SPI, USB, UART or SDIO host interface.
// - UART host mode turns shared pins into receive, transmit, RTS, CTS (here on dedicated UART ports; shared pins stay undriven).
// - Coexistence mode drives active-high radio transmit indication.
// - Supply control output low in deep sleep, high when leaving it.
package hsph_pkg;

  // ==========================================================
  // Host interface selection
  typedef enum logic [1:0] {
    HSPH_SPI  = 2'h0,
    HSPH_USB  = 2'h1,
    HSPH_UART = 2'h2,
    HSPH_SDIO = 2'h3
  } hsph_mode_e;

  localparam hsph_mode_e HSPH_MODE_RST = HSPH_SDIO;
  localparam logic [1:0] HSPH_STRAP_SETTLE = 2'h3; // Cycles before latch

  // ==========================================================
  // Interrupt output styles
  typedef enum logic [1:0] {
    HSPH_IRQ_HIGH  = 2'h0,
    HSPH_IRQ_LOW   = 2'h1,
    HSPH_IRQ_DRAIN = 2'h2
  } hsph_irq_e;

  // ==========================================================
  // Sleep states, Gray along awake-light-deep
  typedef enum logic [1:0] {
    HSPH_AWAKE = 2'h0,
    HSPH_LIGHT = 2'h1,
    HSPH_DEEP  = 2'h3
  } hsph_sleep_e;

  // Sleep indication pins
  typedef struct packed {
    logic status_a;
    logic status_b;
    logic supply_on;
  } hsph_sleep_s;

  localparam hsph_sleep_s HSPH_SLEEP_RST = 3'h7;

  // ==========================================================
  // Synchroniser bit positions
  localparam int HSPH_S_SEL0   = 0;
  localparam int HSPH_S_SEL1   = 1;
  localparam int HSPH_S_CMD    = 2;
  localparam int HSPH_S_DAT    = 3;
  localparam int HSPH_S_RX     = 7;
  localparam int HSPH_S_CTS    = 8;
  localparam int HSPH_S_BYPASS = 9;
  localparam int HSPH_S_DWAKE  = 10;
  localparam int HSPH_S_PRIO   = 11;
  localparam int HSPH_S_PACT   = 12;
  localparam int HSPH_S_WIDTH  = 13;

endpackage : hsph_pkg

// [design/hsph_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module hsph_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage read only by second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : hsph_sync

`default_nettype wire

// [sim/hsph_host_model.sv]
// Host processor model: strap pins, shared host pins, UART loopback
`timescale 1ns/100ps
`default_nettype none

module hsph_host_model (
  input  wire logic       clk,
  input  wire logic [1:0] strap,
  input  wire logic       sel_low,
  input  wire logic       cmd_out,
  input  wire logic       cmd_oe,
  input  wire logic [3:0] dat_out,
  input  wire logic [3:0] dat_oe,
  input  wire logic       tx,
  input  wire logic       tx_oe,
  input  wire logic       rts,
  input  wire logic       rts_oe,
  output var  logic       sel_0,
  output var  logic       sel_1,
  output var  logic       cmd_in,
  output var  logic [3:0] dat_in,
  output var  logic       rx,
  output var  logic       cts
);
  logic [3:0] churn = 4'h0;

  // ==========================================
  // Pattern for released lines, never a stale level
  always_ff @(posedge clk) begin
    churn <= churn + 4'h1;
  end

  // Strap pins, driven straight from the strap vector
  assign sel_0 = strap[0];
  assign sel_1 = strap[1];
  // Host owns the select line only in SPI mode
  assign cmd_in = cmd_oe ? cmd_out : ((strap == 2'h2) ? !sel_low : churn[0]);
  assign dat_in = (dat_oe & dat_out) | (~dat_oe & churn);
  // UART wired back on itself
  assign rx = tx_oe ? tx : churn[1];
  assign cts = rts_oe ? rts : churn[2];
endmodule : hsph_host_model

`default_nettype wire

// [sim/hsph_host_select_tb_top.sv]
// Self-checking testbench of the host select and power handshake block
`timescale 1ns/100ps
`default_nettype none

module hsph_host_select_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap = 2'h3;
  logic sel_low, spi_tx_bit, sdio_cmd_tx, sdio_cmd_tx_en, irq_req;
  logic wake_irq_en, wake_active_low, pkt_pending, serial_tx_data;
  logic serial_rts_req, boot_done, boot_bypass_in, light_sleep_req;
  logic deep_sleep_req, handshake_en, deep_sleep_wake_in, coex_en;
  logic wlan_tx_busy, peer_priority_in, peer_tx_active_in;
  logic [3:0] sdio_dat_tx, sdio_dat_tx_en, host_dat_in, host_dat_out;
  logic [3:0] host_dat_oe, host_dat_rx;
  hsph_pkg::hsph_irq_e irq_style;
  hsph_pkg::hsph_mode_e host_mode;
  hsph_pkg::hsph_sleep_e sleep_state;
  hsph_pkg::hsph_sleep_s sleep_pins;
  logic host_sel_0_in, host_sel_1_in, strap_done, host_cmd_in, host_cmd_out;
  logic host_cmd_oe, host_cmd_rx, spi_active, host_wake_out, host_wake_oe;
  logic host_serial_rx, host_serial_tx, host_serial_tx_oe, host_serial_rts;
  logic host_serial_rts_oe, host_serial_cts, serial_rx_data, serial_cts_seen;
  logic skip_host_cmds, radio_tx_active_out, peer_priority, peer_tx_active;
  int err_count = 0;
  int n_checks = 0;

  // ==========================================
  // Block under test and host model
  hsph_host_select dut (.clk, .rst_n, .host_sel_0_in, .host_sel_1_in,
    .host_mode, .strap_done, .host_cmd_in, .host_cmd_out, .host_cmd_oe,
    .host_dat_in, .host_dat_out, .host_dat_oe, .host_cmd_rx, .host_dat_rx,
    .spi_active, .spi_tx_bit, .sdio_cmd_tx, .sdio_cmd_tx_en, .sdio_dat_tx,
    .sdio_dat_tx_en, .irq_req, .irq_style, .wake_irq_en, .wake_active_low,
    .pkt_pending, .host_wake_out, .host_wake_oe, .host_serial_rx,
    .host_serial_tx, .host_serial_tx_oe, .host_serial_rts,
    .host_serial_rts_oe, .host_serial_cts, .serial_rx_data, .serial_cts_seen,
    .serial_tx_data, .serial_rts_req, .boot_done, .boot_bypass_in,
    .skip_host_cmds, .light_sleep_req, .deep_sleep_req, .handshake_en,
    .deep_sleep_wake_in, .sleep_state, .sleep_pins, .coex_en, .wlan_tx_busy,
    .radio_tx_active_out, .peer_priority_in, .peer_tx_active_in,
    .peer_priority, .peer_tx_active);

  hsph_host_model host (.clk, .strap, .sel_low, .cmd_out(host_cmd_out),
    .cmd_oe(host_cmd_oe), .dat_out(host_dat_out), .dat_oe(host_dat_oe),
    .tx(host_serial_tx), .tx_oe(host_serial_tx_oe), .rts(host_serial_rts),
    .rts_oe(host_serial_rts_oe), .sel_0(host_sel_0_in),
    .sel_1(host_sel_1_in), .cmd_in(host_cmd_in), .dat_in(host_dat_in),
    .rx(host_serial_rx), .cts(host_serial_cts));

  // ==========================================
  // Clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts, verdict, end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Let edges land, then look
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Reset two cycles with given straps, bounded wait for the latch
  task automatic boot(input logic [1:0] s);
    int i;
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8 && strap_done !== 1'b1; i++) step(1);
    if (strap_done !== 1'b1) begin
      err_count++;
      close_out();
    end
    step(1);
  endtask : boot

  // Every strap code; USB mode leaves the shared pins and UART transmit undriven
  task automatic t_straps;
    logic [1:0] want [4];
    int k;
    want = '{2'h2, 2'h1, 2'h0, 2'h3};
    for (k = 0; k < 4; k++) begin
      boot(k[1:0]);
      chk(host_mode, want[k]);
      if (k == 1) chk({host_cmd_oe, host_dat_oe, host_serial_tx_oe}, 8'h0);
    end
    $display("strap test done");
  endtask : t_straps

  // Select, slave output and every interrupt style
  task automatic t_spi;
    logic [1:0] want [6];
    int k;
    want = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h0, 2'h2};
    boot(2'h2);
    @(posedge clk);
    sel_low <= 1'b1;
    spi_tx_bit <= 1'b1;
    step(3);
    chk({host_dat_oe[1], host_dat_out[1], spi_active}, 8'h7);
    @(posedge clk);
    spi_tx_bit <= 1'b0;
    step(1);
    chk(host_dat_out[1], 8'h0);
    for (k = 0; k < 6; k++) begin
      @(posedge clk);
      irq_style <= hsph_pkg::hsph_irq_e'(k / 2);
      irq_req <= k[0];
      step(1);
      chk({host_dat_oe[2], host_dat_out[2]}, want[k]);
    end
    @(posedge clk);
    sel_low <= 1'b0;
    step(3);
    chk({host_dat_oe[1], spi_active}, 8'h0);
    $display("spi test done");
  endtask : t_spi

  // SDIO lines per enable, wakeup pin in both polarities
  task automatic t_sdio;
    boot(2'h3);
    @(posedge clk);
    {sdio_cmd_tx, sdio_cmd_tx_en, wake_irq_en, pkt_pending} <= 4'hf;
    {sdio_dat_tx, sdio_dat_tx_en, wake_active_low} <= 9'h0cb;
    step(1);
    chk({host_cmd_oe, host_cmd_out, host_dat_oe}, 8'h35);
    chk(host_dat_out & host_dat_oe, 8'h4);
    chk({host_wake_oe, host_wake_out}, 8'h2);
    @(posedge clk);
    wake_active_low <= 1'b0;
    step(1);
    chk({host_wake_oe, host_wake_out}, 8'h3);
    @(posedge clk);
    pkt_pending <= 1'b0;
    step(1);
    chk({host_wake_oe, host_wake_out}, 8'h2);
    // Driven lines come back through the synchroniser
    chk({host_cmd_rx, host_dat_rx & 4'h5}, 8'h14);
    $display("sdio test done");
  endtask : t_sdio

  // UART pins driven and looped back through the host
  task automatic t_uart;
    int k;
    boot(2'h0);
    for (k = 1; k >= 0; k--) begin
      @(posedge clk);
      serial_tx_data <= k[0];
      serial_rts_req <= 1'b1;
      step(3);
      chk({host_serial_tx_oe, host_serial_tx, host_serial_rts_oe,
           host_serial_rts, serial_rx_data, serial_cts_seen},
          {1'b1, k[0], 1'b1, 1'b1, k[0], 1'b1});
    end
    $display("uart test done");
  endtask : t_uart

  // Deep sleep walk, then light sleep with bypass before and after boot
  task automatic t_sleep;
    boot(2'h3);
    @(posedge clk);
    handshake_en <= 1'b1;
    irq_req <= 1'b0;
    deep_sleep_req <= 1'b1;
    @(posedge clk);
    deep_sleep_req <= 1'b0;
    #1;
    chk({sleep_state, sleep_pins}, {hsph_pkg::HSPH_DEEP, 3'h0});
    @(posedge clk);
    deep_sleep_wake_in <= 1'b1;
    step(2);
    chk(sleep_state, hsph_pkg::HSPH_DEEP);
    step(1);
    chk({sleep_state, sleep_pins}, {hsph_pkg::HSPH_AWAKE, 3'h7});
    @(posedge clk);
    deep_sleep_wake_in <= 1'b0;
    irq_req <= 1'b1;
    light_sleep_req <= 1'b1;
    @(posedge clk);
    light_sleep_req <= 1'b0;
    boot_bypass_in <= 1'b1;
    #1;
    chk({sleep_state, sleep_pins}, {hsph_pkg::HSPH_LIGHT, 3'h3});
    step(3);
    chk({skip_host_cmds, sleep_state}, {1'b1, hsph_pkg::HSPH_LIGHT});
    @(posedge clk);
    boot_done <= 1'b1;
    step(1);
    chk({skip_host_cmds, sleep_state, sleep_pins}, {1'b0, 5'h07});
    @(posedge clk);
    boot_bypass_in <= 1'b0;
    // Handshake off, both requests at once: deep wins, status A stays high
    handshake_en <= 1'b0;
    light_sleep_req <= 1'b1;
    deep_sleep_req <= 1'b1;
    @(posedge clk);
    {light_sleep_req, deep_sleep_req} <= 2'h0;
    #1;
    chk({sleep_state, sleep_pins}, {hsph_pkg::HSPH_DEEP, 3'h4});
    $display("sleep test done");
  endtask : t_sleep

  // Coexistence signals both ways, then gated off
  task automatic t_coex;
    @(posedge clk);
    {coex_en, wlan_tx_busy, peer_priority_in, peer_tx_active_in} <= 4'he;
    step(3);
    chk({radio_tx_active_out, peer_priority, peer_tx_active}, 8'h6);
    @(posedge clk);
    {wlan_tx_busy, peer_priority_in, peer_tx_active_in} <= 3'h1;
    step(3);
    chk({radio_tx_active_out, peer_priority, peer_tx_active}, 8'h1);
    @(posedge clk);
    coex_en <= 1'b0;
    step(1);
    chk({peer_priority, peer_tx_active}, 8'h0);
    $display("coex test done");
  endtask : t_coex

  // ==========================================
  // Main sequence
  initial begin
    {sel_low, spi_tx_bit, sdio_cmd_tx, sdio_cmd_tx_en, irq_req} = '0;
    {wake_irq_en, wake_active_low, pkt_pending, serial_tx_data} = '0;
    {serial_rts_req, boot_done, boot_bypass_in, light_sleep_req} = '0;
    {deep_sleep_req, handshake_en, deep_sleep_wake_in, coex_en} = '0;
    {wlan_tx_busy, peer_priority_in, peer_tx_active_in} = '0;
    {sdio_dat_tx, sdio_dat_tx_en} = '0;
    irq_style = hsph_pkg::HSPH_IRQ_HIGH;
    @(posedge clk);
    irq_req <= 1'b1;
    sdio_dat_tx_en <= 4'hf;
    t_straps();
    t_spi();
    t_sdio();
    t_uart();
    t_sleep();
    t_coex();
    close_out();
  end
endmodule : hsph_host_select_tb_top

`default_nettype wire
